// ---- pkg/sram_host_pkg.sv ----
/*
 package for the static memory host controller: register map, fields,
 timing constants and states.
 assumes a 100 MHz sys_clk.
*/
`default_nettype none
package sram_host_pkg;
  // avalon register word addresses (byte address / 4)
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_addr = 4'h1;
  localparam logic [3:0] reg_wdata = 4'h2;
  localparam logic [3:0] reg_rdata = 4'h3;
  localparam logic [3:0] reg_status = 4'h4;
  // ctrl fields
  localparam int ctrl_go_bit = 0;
  localparam int ctrl_write_bit = 1;
  localparam int ctrl_lower_bit = 2;
  localparam int ctrl_upper_bit = 3;
  localparam int ctrl_wide_bit = 4;
  // status fields
  localparam int stat_busy_bit = 0;
  localparam int stat_corr_bit = 1;
  localparam int stat_wide_bit = 2;
  localparam logic [31:0] unmapped_value = 32'h0000_0000;
  localparam logic [4:0] ctrl_reset = 5'h10;
  // timing in ns and derived cycle counts at 100 MHz
  localparam int clk_period_ns = 10;
  localparam int read_cycle_ns = 55;
  localparam int select_to_end_ns = 40;
  localparam int strobe_to_float_delay_ns = 18;
  localparam int input_setup_before_end_ns = 25;
  localparam int float_after_ns = 18;
  localparam int read_cycles =
    (read_cycle_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int strobe_ns_min =
    strobe_to_float_delay_ns + input_setup_before_end_ns;
  localparam int strobe_ns =
    (strobe_ns_min > select_to_end_ns) ? strobe_ns_min : select_to_end_ns;
  localparam int write_cycles =
    (strobe_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int turn_cycles =
    (float_after_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] read_count = 4'(read_cycles);
  localparam logic [3:0] write_count = 4'(write_cycles);
  localparam logic [3:0] turn_count = 4'(turn_cycles);
  localparam logic [20:0] addr_reset = 21'h00_0000;
  localparam logic [15:0] data_reset = 16'h0000;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_setup = 3'b001,
    st_active = 3'b011,
    st_end = 3'b010,
    st_turn = 3'b110
  } phase_e;
endpackage
`default_nettype wire

// ---- hw/cycle_timer.sv ----
/*
 down counter that raises done when loaded count has elapsed.
 assumes a single sys_clk domain.
*/
`default_nettype none
module cycle_timer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [3:0] count,
  output logic done
);
  typedef struct packed {
    logic [3:0] left;
  } timer_s;
  timer_s cur, next_cur;

  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.left = count;
    end else if (cur.left != 4'h0) begin
      next_cur.left = cur.left - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done = (cur.left == 4'h1) && !load;
endmodule // cycle_timer
`default_nettype wire

// ---- hw/sram_host.sv ----
/*
 host controller for an asynchronous ecc static memory: avalon-mm slave
 registers order single reads and writes that are played onto the pins.
 assumes the memory answers within its 55 ns access time, 100 MHz clock.
*/
// Added by the designer: the address map and the Avalon-MM register port.
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Operation
// - address is steady before the combined select falls.
// - write data held around the strobe edge that ends the write.
// - host never drives data while memory may still drive it.
// - write strobe held at least float delay plus data setup.
// - width strap high for 16-bit words, low for bytes.
module sram_host (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [20:0] mem_addr,
  output logic primary_select_n,
  output logic secondary_select,
  output logic store_strobe_n,
  output logic drive_enable_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  output logic width_select,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  input wire logic corrected_flag
);
  typedef struct packed {
    sram_host_pkg::phase_e phase;
    logic [4:0] ctrl;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic corr;
    logic [31:0] rd;
    logic waitreq;
    logic [20:0] pa;
    logic p1n, p2, wen, oen, ubn, lbn, wide;
    logic [15:0] dout;
    logic [15:0] doe;
  } host_s;
  host_s cur, next_cur;
  logic t_load, t_done;
  logic [3:0] t_count;
  logic is_wr, lane_lo, lane_hi, busy;

  cycle_timer i_cycle_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cur = cur;
    t_load = 1'b0;
    t_count = sram_host_pkg::read_count;
    is_wr = cur.ctrl[sram_host_pkg::ctrl_write_bit];
    // narrow mode: lanes are don't care, drive both active
    lane_lo = cur.ctrl[sram_host_pkg::ctrl_lower_bit] || !cur.wide;
    lane_hi = cur.ctrl[sram_host_pkg::ctrl_upper_bit] || !cur.wide;
    // a pending go counts as busy so a late ctrl write cannot lose it
    busy = (cur.phase != sram_host_pkg::st_idle)
      || cur.ctrl[sram_host_pkg::ctrl_go_bit];
    next_cur.waitreq = 1'b1;
    // one-cycle answer: waitrequest drops only for the cycle after taking
    if ((avs_read || avs_write) && cur.waitreq) begin
      next_cur.waitreq = 1'b0;
      next_cur.rd = sram_host_pkg::unmapped_value;
      if (avs_read) begin
        case (avs_address)
          sram_host_pkg::reg_ctrl: next_cur.rd = 32'(cur.ctrl);
          sram_host_pkg::reg_addr: next_cur.rd = 32'(cur.addr);
          sram_host_pkg::reg_wdata: next_cur.rd = 32'(cur.wdata);
          sram_host_pkg::reg_rdata: next_cur.rd = 32'(cur.rdata);
          sram_host_pkg::reg_status: next_cur.rd = 32'({cur.wide, cur.corr,
            busy});
          default: next_cur.rd = sram_host_pkg::unmapped_value;
        endcase
      end
    end
    // a write lands at the edge where the master sees waitrequest low
    if (avs_write && !cur.waitreq && !busy) begin
      // writes while busy are dropped so pins stay stable
      case (avs_address)
        sram_host_pkg::reg_ctrl: next_cur.ctrl = avs_writedata[4:0];
        sram_host_pkg::reg_addr: next_cur.addr = avs_writedata[20:0];
        sram_host_pkg::reg_wdata: next_cur.wdata = avs_writedata[15:0];
        default: next_cur.ctrl = cur.ctrl;
      endcase
    end
    case (cur.phase)
      sram_host_pkg::st_idle: begin
        next_cur.wide = cur.ctrl[sram_host_pkg::ctrl_wide_bit];
        if (cur.ctrl[sram_host_pkg::ctrl_go_bit]) begin
          next_cur.ctrl[sram_host_pkg::ctrl_go_bit] = 1'b0;
          next_cur.pa = cur.addr;
          next_cur.phase = sram_host_pkg::st_setup;
        end
      end
      sram_host_pkg::st_setup: begin
        // address settled a cycle before select, strobe, lanes go active
        next_cur.p1n = 1'b0;
        next_cur.p2 = 1'b1;
        next_cur.lbn = !lane_lo;
        next_cur.ubn = !lane_hi;
        // no lane in wide mode: access runs deselected, strobe stays high
        next_cur.wen = !(is_wr && (lane_lo || lane_hi));
        next_cur.oen = is_wr;
        next_cur.phase = sram_host_pkg::st_active;
        t_load = 1'b1;
        t_count = is_wr ? sram_host_pkg::write_count
                        : sram_host_pkg::read_count;
        if (is_wr) begin
          next_cur.dout = cur.wdata;
          // narrow bytes travel on bits 0 to 7 only
          next_cur.doe = cur.wide ? {{8{lane_hi}}, {8{lane_lo}}}
                                  : 16'h00ff;
        end
      end
      sram_host_pkg::st_active: begin
        if (t_done) begin
          next_cur.phase = sram_host_pkg::st_end;
          // strobe alone ends the write; data held one more cycle
          next_cur.wen = 1'b1;
          next_cur.oen = 1'b1;
          if (!is_wr) begin
            next_cur.rdata[7:0] = lane_lo ? data_in[7:0] : 8'h00;
            next_cur.rdata[15:8] = (lane_hi && cur.wide) ? data_in[15:8]
                                                         : 8'h00;
            next_cur.corr = corrected_flag;
          end
        end
      end
      sram_host_pkg::st_end: begin
        next_cur.doe = 16'h0000;
        next_cur.p1n = 1'b1;
        next_cur.p2 = 1'b0;
        next_cur.lbn = 1'b1;
        next_cur.ubn = 1'b1;
        next_cur.phase = sram_host_pkg::st_turn;
        t_load = 1'b1;
        t_count = sram_host_pkg::turn_count;
      end
      sram_host_pkg::st_turn: begin
        if (t_done) begin
          next_cur.phase = sram_host_pkg::st_idle;
        end
      end
      default: next_cur.phase = sram_host_pkg::st_idle;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
      cur.phase <= sram_host_pkg::st_idle;
      cur.ctrl <= sram_host_pkg::ctrl_reset;
      cur.addr <= sram_host_pkg::addr_reset;
      cur.wdata <= sram_host_pkg::data_reset;
      cur.rdata <= sram_host_pkg::data_reset;
      cur.wide <= 1'b1;
      cur.waitreq <= 1'b1;
      cur.p1n <= 1'b1;
      cur.wen <= 1'b1;
      cur.oen <= 1'b1;
      cur.ubn <= 1'b1;
      cur.lbn <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign avs_readdata = cur.rd;
  assign avs_waitrequest = cur.waitreq;
  assign mem_addr = cur.pa;
  assign primary_select_n = cur.p1n;
  assign secondary_select = cur.p2;
  assign store_strobe_n = cur.wen;
  assign drive_enable_n = cur.oen;
  assign upper_lane_select_n = cur.ubn;
  assign lower_lane_select_n = cur.lbn;
  assign width_select = cur.wide;
  assign data_out = cur.dout;
  assign data_oe = cur.doe;

  ////////////////////////////////////////////////////////////////////////
  a_no_contention: assert property (@(posedge sys_clk) disable iff (reset)
    (cur.doe != 16'h0000) |-> cur.oen)
    else $error("data driven while memory output enabled");
  a_addr_stable: assert property (@(posedge sys_clk) disable iff (reset)
    (!cur.p1n && $past(!cur.p1n)) |-> $stable(cur.pa))
    else $error("address moved while selected");
  a_strobe_width: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(cur.wen) |-> !cur.wen [*5])
    else $error("write strobe too short");
  a_data_hold: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(cur.wen) |-> (cur.doe != 16'h0000))
    else $error("write data dropped with strobe");
  a_write_select: assert property (@(posedge sys_clk) disable iff (reset)
    !cur.wen |-> (!cur.p1n && cur.p2 && !(cur.ubn && cur.lbn)))
    else $error("strobe low outside qualified write");
  a_strobe_first: assert property (@(posedge sys_clk) disable iff (reset)
    ($rose(cur.p1n)) |-> $past(cur.wen))
    else $error("select released before strobe");
  a_narrow_lanes: assert property (@(posedge sys_clk) disable iff (reset)
    (!cur.wide && cur.doe != 16'h0000) |-> cur.doe == 16'h00ff)
    else $error("narrow write drove upper byte");
  a_idle_deselect: assert property (@(posedge sys_clk) disable iff (reset)
    (cur.phase == sram_host_pkg::st_idle) |-> (cur.p1n && cur.ubn
      && cur.lbn))
    else $error("memory selected while idle");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus not answered in one cycle");
  c_write: cover property (@(posedge sys_clk) $rose(cur.wen));
  c_read: cover property (@(posedge sys_clk)
    $rose(cur.oen) && !is_wr);
  c_corrected: cover property (@(posedge sys_clk) $rose(cur.corr));
  c_narrow: cover property (@(posedge sys_clk) !cur.wide && !cur.p1n);
endmodule // sram_host
`default_nettype wire

// ---- tb/sram_model.sv ----
/*
 behavioural ecc static memory on the host pins, with fault flags.
 assumes the host drives registered pins; the data wire is resolved here.
*/
`default_nettype none
module sram_model (
  input wire logic [20:0] mem_addr,
  input wire logic primary_select_n,
  input wire logic secondary_select,
  input wire logic store_strobe_n,
  input wire logic drive_enable_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic width_select,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic inject,
  output logic [15:0] data_in,
  output logic corrected_flag,
  output logic [2:0] viol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic junk = 1'b0;
  logic sel, on, wr;
  logic [15:0] drv, word;
  time t0 = 0;
  initial viol = 3'b000;
  // floating lines toggle so a stale value never passes for data
  always #5 junk = ~junk;
  assign sel = !primary_select_n && secondary_select;
  assign on = sel && !(width_select && upper_lane_select_n
    && lower_lane_select_n);
  assign wr = on && !store_strobe_n;
  assign word = mem[mem_addr[7:0]];
  always_comb begin
    drv = 16'h0000;
    if (on && store_strobe_n && !drive_enable_n) begin
      drv[7:0] = (!width_select || !lower_lane_select_n) ? 8'hff : 8'h00;
      drv[15:8] = (width_select && !upper_lane_select_n) ? 8'hff : 8'h00;
    end
  end
  assign data_in = (data_oe & data_out) | (~data_oe & drv & word)
    | (~data_oe & ~drv & {16{junk}});
  // correction shows on the flag only, stored word untouched
  assign corrected_flag = (|drv) ? inject : junk;
  always @(negedge wr) begin
    if (!width_select) begin
      mem[mem_addr[7:0]][7:0] = data_in[7:0];
    end else begin
      if (!lower_lane_select_n) mem[mem_addr[7:0]][7:0] = data_in[7:0];
      if (!upper_lane_select_n) mem[mem_addr[7:0]][15:8] = data_in[15:8];
    end
  end
  always @(mem_addr) if (sel === 1'b1) viol[0] = 1'b1;
  always @(negedge store_strobe_n) t0 = $time;
  always @(posedge store_strobe_n)
    if (sel === 1'b1 && $time - t0 < sram_host_pkg::strobe_to_float_delay_ns
      + sram_host_pkg::input_setup_before_end_ns) viol[1] = 1'b1;
  always @(data_oe or drv) #1 if (|(data_oe & drv)) viol[2] = 1'b1;
endmodule // sram_model
`default_nettype wire

// ---- tb/sram_host_test.sv ----
/*
 self-checking bench for the static memory host controller.
 assumes the memory model beside it and a 100 MHz clock.
*/
`default_nettype none
module sram_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic inject = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, primary_select_n, secondary_select, store_strobe_n;
  logic drive_enable_n, upper_lane_select_n, lower_lane_select_n;
  logic width_select, corrected_flag;
  logic [20:0] mem_addr;
  logic [15:0] data_in, data_out, data_oe;
  logic [2:0] viol;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  sram_host i_sram_host (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr,
    .primary_select_n, .secondary_select, .store_strobe_n, .drive_enable_n,
    .upper_lane_select_n, .lower_lane_select_n, .width_select, .data_in,
    .data_out, .data_oe, .corrected_flag);
  sram_model i_sram_model (.mem_addr, .primary_select_n, .secondary_select,
    .store_strobe_n, .drive_enable_n, .upper_lane_select_n,
    .lower_lane_select_n, .width_select, .data_out, .data_oe, .inject,
    .data_in, .corrected_flag, .viol);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end
  // one avalon transfer; request held until waitrequest samples low
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) check(32'h0000_0000, 32'h0000_0001, "bus hang");
  endtask
  task automatic op(input logic [4:0] c, input logic [20:0] a,
    input logic [15:0] d);
    int n = 0;
    bus(1'b1, sram_host_pkg::reg_addr, 32'(a));
    bus(1'b1, sram_host_pkg::reg_wdata, 32'(d));
    bus(1'b1, sram_host_pkg::reg_ctrl, 32'(c));
    do begin
      bus(1'b0, sram_host_pkg::reg_status, 32'h0000_0000);
      n++;
    end while (q[sram_host_pkg::stat_busy_bit] !== 1'b0 && n < 50);
    if (n == 50) check(32'h0000_0000, 32'h0000_0001, "op hang");
  endtask
  task automatic rd(input logic [4:0] c, input logic [20:0] a,
    input logic [15:0] mask, input logic [15:0] exp);
    op(c, a, 16'h0000);
    bus(1'b0, sram_host_pkg::reg_rdata, 32'h0000_0000);
    check(32'(q[15:0] & mask), 32'(exp), "read data");
  endtask
  task automatic stat(input logic [2:0] exp);
    bus(1'b0, sram_host_pkg::reg_status, 32'h0000_0000);
    check(32'(q[2:0]), 32'(exp), "status");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // ctrl: go 01, write 02, lower 04, upper 08, wide 10
  task automatic t_basic();
    stat(3'b100);
    bus(1'b0, 4'h7, 32'h0000_0000);
    check(q, sram_host_pkg::unmapped_value, "unmapped");
    op(5'h1f, 21'h00_0010, 16'ha55a);
    rd(5'h1d, 21'h00_0010, 16'hffff, 16'ha55a);
    $display("basic done");
  endtask
  task automatic t_lanes();
    op(5'h17, 21'h00_0010, 16'h1234);
    op(5'h1b, 21'h00_0010, 16'h7788);
    rd(5'h1d, 21'h00_0010, 16'hffff, 16'h7734);
    rd(5'h15, 21'h00_0010, 16'h00ff, 16'h0034);
    rd(5'h19, 21'h00_0010, 16'hff00, 16'h7700);
    $display("lanes done");
  endtask
  task automatic t_narrow();
    op(5'h03, 21'h00_0020, 16'hbeef);
    rd(5'h01, 21'h00_0020, 16'h00ff, 16'h00ef);
    stat(3'b000);
    $display("narrow done");
  endtask
  task automatic t_nolane();
    op(5'h1f, 21'h00_0030, 16'h1111);
    op(5'h13, 21'h00_0030, 16'h2222);
    rd(5'h1d, 21'h00_0030, 16'hffff, 16'h1111);
    $display("nolane done");
  endtask
  task automatic t_ecc();
    inject <= 1'b1;
    rd(5'h1d, 21'h00_0010, 16'hffff, 16'h7734);
    stat(3'b110);
    inject <= 1'b0;
    rd(5'h1d, 21'h00_0010, 16'hffff, 16'h7734);
    stat(3'b100);
    $display("ecc done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_basic();
    t_lanes();
    t_narrow();
    t_nolane();
    t_ecc();
    check(32'(viol[0]), 32'h0000_0000, "address moved");
    check(32'(viol[1]), 32'h0000_0000, "short strobe");
    check(32'(viol[2]), 32'h0000_0000, "contention");
    final_report();
  end
endmodule // sram_host_test
`default_nettype wire
